// ---- rtl/subtract_skip_alu_ops.sv ----
// Purpose: executes the subtract, skip, set and swap group on accumulator, memory and flags
// Assumes: issue is valid for one mclk cycle; operand is the memory byte or immediate
// Notes: skip_req marks that the already fetched instruction must be flushed
`timescale 1ns/1ns
module subtract_skip_alu_ops (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic issue_valid,
	input alu_pkg::issue_s issue,
	output logic [7:0] acc,
	output logic [7:0] flags,
	output alu_pkg::mem_wr_s mem_wr,
	output logic skip_req,
	output logic dummy_cycle,
	output logic busy
);
	logic [7:0] acc_reg, acc_next;
	logic [7:0] flags_reg, flags_next;
	alu_pkg::mem_wr_s mem_reg, mem_next;
	logic skip_reg, skip_next;
	logic dummy_reg;
	logic [7:0] sum;
	logic cout, half, range, cin;
	logic [7:0] dec_v, inc_v;

	function automatic logic [7:0] one_hot(input logic [2:0] s);
		one_hot = 8'h01 << s;
	endfunction

	function automatic logic [7:0] arith_flags(input logic [7:0] f, input logic [7:0] r,
		input logic c, input logic h, input logic v, input logic use_v);
		arith_flags = f;
		arith_flags[alu_pkg::FLAG_C] = c;
		arith_flags[alu_pkg::FLAG_HC] = h;
		arith_flags[alu_pkg::FLAG_Z] = (r == 8'h00);
		if (use_v) begin
			arith_flags[alu_pkg::FLAG_RANGE] = v;
		end
	endfunction

	always_comb begin
		cin = 1'b1;
		if (issue.op == alu_pkg::minus_with_borrow_to_accum || issue.op == alu_pkg::minus_with_borrow_to_mem) begin
			cin = flags_reg[alu_pkg::FLAG_C];
		end
	end

	sub_adder u_add (
		.a(acc_reg),
		.b(issue.operand),
		.cin(cin),
		.sum(sum),
		.cout(cout),
		.half(half),
		.range(range)
	);

	assign dec_v = issue.operand - 8'h01;
	assign inc_v = issue.operand + 8'h01;

	always_comb begin
		acc_next = acc_reg;
		flags_next = flags_reg; // RULE14
		mem_next = '0;
		skip_next = 1'b0;
		if (issue_valid && !dummy_reg) begin
			unique case (issue.op)
				alu_pkg::rotate_right_carry_to_accum: begin
					acc_next = {flags_reg[alu_pkg::FLAG_C], issue.operand[7:1]}; // RULE1
					flags_next[alu_pkg::FLAG_C] = issue.operand[0]; // RULE1
				end
				alu_pkg::minus_with_borrow_to_accum: begin
					acc_next = sum; // RULE2
					flags_next = arith_flags(flags_reg, sum, cout, half, range, 1'b1); // RULE2
				end
				alu_pkg::minus_with_borrow_to_mem: begin
					mem_next = '{wr: 1'b1, data: sum}; // RULE2
					flags_next = arith_flags(flags_reg, sum, cout, half, range, 1'b1); // RULE2
				end
				alu_pkg::decrement_skip_zero: begin
					mem_next = '{wr: 1'b1, data: dec_v}; // RULE3
					skip_next = (dec_v == 8'h00); // RULE3
				end
				alu_pkg::decrement_to_accum_skip_zero: begin
					acc_next = dec_v; // RULE4
					skip_next = (dec_v == 8'h00); // RULE4
				end
				alu_pkg::fill_ones_mem: mem_next = '{wr: 1'b1, data: alu_pkg::ALL_ONES}; // RULE6
				alu_pkg::set_bit_mem: mem_next = '{wr: 1'b1, data: issue.operand | one_hot(issue.bit_sel)}; // RULE7
				alu_pkg::increment_skip_zero: begin
					mem_next = '{wr: 1'b1, data: inc_v}; // RULE8
					skip_next = (inc_v == 8'h00); // RULE8
				end
				alu_pkg::increment_to_accum_skip_zero: begin
					acc_next = inc_v; // RULE9
					skip_next = (inc_v == 8'h00); // RULE9
				end
				alu_pkg::bit_test_skip_nonzero: begin
					skip_next = |(issue.operand & one_hot(issue.bit_sel)); // RULE10
				end
				alu_pkg::minus_to_accum: begin
					acc_next = sum; // RULE11
					flags_next = arith_flags(flags_reg, sum, cout, half, range, 1'b1); // RULE11
				end
				alu_pkg::minus_to_mem: begin
					mem_next = '{wr: 1'b1, data: sum}; // RULE11
					flags_next = arith_flags(flags_reg, sum, cout, half, range, 1'b0); // RULE11
				end
				alu_pkg::minus_imm_to_accum: begin
					acc_next = sum; // RULE12
					flags_next = arith_flags(flags_reg, sum, cout, half, range, 1'b1); // RULE12
				end
				alu_pkg::swap_nibbles_mem: begin
					mem_next = '{wr: 1'b1, data: {issue.operand[3:0], issue.operand[7:4]}}; // RULE13
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg <= alu_pkg::ACC_RESET;
		end else begin
			acc_reg <= acc_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg <= alu_pkg::FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mem_reg <= '0;
		end else begin
			mem_reg <= mem_next;
		end
	end

	// skip pulse and, in the same cycle, a dummy slot that ignores the discarded fetch
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			skip_reg <= 1'b0;
			dummy_reg <= 1'b0;
		end else begin
			skip_reg <= skip_next; // RULE5
			dummy_reg <= skip_next; // RULE5
		end
	end

	assign acc = acc_reg;
	assign flags = flags_reg;
	assign mem_wr = mem_reg;
	assign skip_req = skip_reg;
	assign dummy_cycle = dummy_reg;
	assign busy = dummy_reg;

	skip_dummy_a: assert property (@(posedge mclk) disable iff (!rst_n)
		skip_next |=> skip_req && dummy_cycle ##1 !dummy_cycle) else $error("skip without one dummy cycle"); // RULE5
	flush_ignore_a: assert property (@(posedge mclk) disable iff (!rst_n)
		dummy_cycle |=> !mem_wr.wr && $stable(acc) && $stable(flags)) else $error("discarded instruction took effect"); // RULE5
	rot_carry_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(issue_valid && !dummy_cycle && issue.op == alu_pkg::rotate_right_carry_to_accum) |=>
		acc == {$past(flags[0]), $past(issue.operand[7:1])} && flags[0] == $past(issue.operand[0]) && !mem_wr.wr)
		else $error("rotate through carry wrong"); // RULE1
	dec_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(issue_valid && !dummy_cycle && issue.op == alu_pkg::decrement_skip_zero) |=>
		mem_wr.wr && mem_wr.data == $past(issue.operand) - 8'h01 && skip_req == (mem_wr.data == 8'h00) && $stable(flags))
		else $error("decrement skip wrong"); // RULE3
	inc_acc_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(issue_valid && !dummy_cycle && issue.op == alu_pkg::increment_to_accum_skip_zero) |=>
		acc == $past(issue.operand) + 8'h01 && !mem_wr.wr && skip_req == (acc == 8'h00))
		else $error("increment to accumulator wrong"); // RULE9
	bit_skip_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(issue_valid && !dummy_cycle && issue.op == alu_pkg::bit_test_skip_nonzero) |=>
		skip_req == $past(issue.operand[issue.bit_sel]) && $stable(flags)) else $error("bit test skip wrong"); // RULE10
	fill_ones_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(issue_valid && !dummy_cycle && issue.op == alu_pkg::fill_ones_mem) |=>
		mem_wr.wr && mem_wr.data == 8'hFF && $stable(flags)) else $error("fill ones wrong"); // RULE6
	sub_mem_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(issue_valid && !dummy_cycle && issue.op == alu_pkg::minus_to_mem) |=>
		mem_wr.data == $past(acc) - $past(issue.operand) && flags[3] == $past(flags[3]) && flags[0] == (mem_wr.data <= $past(acc)))
		else $error("subtract to memory wrong"); // RULE11
	high_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$stable(flags[7:4])) else $error("timer or power bits changed"); // RULE14
endmodule

// ---- rtl/alu_pkg.sv ----
// Purpose: shared constants and types for the subtract/skip execution unit
// Assumes: one instruction issued per cycle on mclk
// Notes: flag byte order is timer2, timer1, timeout, powerdown, range, zero, half carry, carry
// Functional notes
// (RULE1) rotate right through carry into accumulator; memory kept, only carry changes
// (RULE2) borrow subtract: acc plus inverted operand plus carry; range, zero, half, carry updated
// (RULE3) decrement memory, write back, skip when result zero; flags kept
// (RULE4) decrement into accumulator, memory kept, skip when zero; flags kept
// (RULE5) true skip discards fetched next instruction, adds dummy cycle: two cycles total
// (RULE6) fill ones writes all ones to memory byte; flags kept
// (RULE7) set one selected memory bit; other bits and flags kept
// (RULE8) increment memory, write back, skip when wraps to zero; flags kept
// (RULE9) increment into accumulator, memory kept, skip when zero; flags kept
// (RULE10) skip when selected memory bit is one; flags kept
// (RULE11) subtract memory: acc plus inverted operand plus one; range only for accumulator form
// (RULE12) subtract immediate into accumulator; range, zero, half, carry updated
// (RULE13) nibble exchange of memory byte written back to same location
// (RULE14) timer and powerdown/timeout bits never change; unlisted flags hold
package alu_pkg;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam int FLAG_C = 0;
	localparam int FLAG_HC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_RANGE = 3;
	localparam int SKIP_CYCLES = 2;
	localparam int PLAIN_CYCLES = 1;

	typedef enum logic [3:0] {
		op_none,
		rotate_right_carry_to_accum,
		minus_with_borrow_to_accum,
		minus_with_borrow_to_mem,
		decrement_skip_zero,
		decrement_to_accum_skip_zero,
		fill_ones_mem,
		set_bit_mem,
		increment_skip_zero,
		increment_to_accum_skip_zero,
		bit_test_skip_nonzero,
		minus_to_accum,
		minus_to_mem,
		minus_imm_to_accum,
		swap_nibbles_mem
	} op_e;

	typedef struct packed {
		op_e op;
		logic [7:0] operand;
		logic [2:0] bit_sel;
	} issue_s;

	typedef struct packed {
		logic wr;
		logic [7:0] data;
	} mem_wr_s;
endpackage

// ---- rtl/sub_adder.sv ----
// Purpose: eight bit adder of acc, inverted operand and carry in, with flag terms
// Assumes: combinational, operands from same clock domain
// Notes: carry out high means no borrow
`timescale 1ns/1ns
module sub_adder (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	output logic [7:0] sum,
	output logic cout,
	output logic half,
	output logic range
);
	logic [8:0] full;
	logic [4:0] low;
	logic [7:0] nb;
	always_comb begin
		nb = ~b;
		full = {1'b0, a} + {1'b0, nb} + {8'h00, cin};
		low = {1'b0, a[3:0]} + {1'b0, nb[3:0]} + {4'h0, cin};
		sum = full[7:0];
		cout = full[8];
		half = low[4];
		range = (a[7] == nb[7]) && (full[7] != a[7]);
	end
endmodule

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the subtract/skip execution unit
// Assumes: results registered one edge after the issue edge
// Notes: expected values come from the reference model inside run
`timescale 1ns/1ns
module tb;
	logic mclk, rst_n, issue_valid, skip_req, dummy_cycle, busy;
	alu_pkg::issue_s issue;
	alu_pkg::mem_wr_s mem_wr;
	logic [7:0] acc, flags, ea;
	logic [3:0] ef;
	int n_mismatch, comparisons;
	subtract_skip_alu_ops u_dut (.mclk(mclk), .rst_n(rst_n), .issue_valid(issue_valid), .issue(issue),
		.acc(acc), .flags(flags), .mem_wr(mem_wr), .skip_req(skip_req), .dummy_cycle(dummy_cycle), .busy(busy));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// model the op, issue it, compare; junk holds a second issue through the dummy cycle
	task automatic run(alu_pkg::op_e o, logic [7:0] m, logic [2:0] bs, logic junk = 1'b0);
		logic [7:0] nb, r;
		logic [8:0] s;
		logic ci, h, sk, wr;
		nb = ~m;
		ci = (o == alu_pkg::minus_with_borrow_to_accum || o == alu_pkg::minus_with_borrow_to_mem) ? ef[0] : 1'b1;
		s = {1'b0, ea} + {1'b0, nb} + {8'h00, ci};
		h = ({1'b0, ea[3:0]} + {1'b0, nb[3:0]} + {4'h0, ci}) > 5'h0F;
		sk = 1'b0;
		wr = 1'b0;
		r = 8'h00;
		case (o)
		alu_pkg::rotate_right_carry_to_accum: begin
			ea = {ef[0], m[7:1]};
			ef[0] = m[0];
		end
		alu_pkg::minus_with_borrow_to_accum, alu_pkg::minus_to_accum, alu_pkg::minus_imm_to_accum,
		alu_pkg::minus_with_borrow_to_mem, alu_pkg::minus_to_mem: begin
			if (o != alu_pkg::minus_to_mem) ef[3] = (ea[7] == nb[7]) && (s[7] != ea[7]);
			ef[2:0] = {s[7:0] == 8'h00, h, s[8]};
			wr = (o == alu_pkg::minus_with_borrow_to_mem || o == alu_pkg::minus_to_mem);
			if (wr) r = s[7:0];
			else ea = s[7:0];
		end
		alu_pkg::decrement_skip_zero, alu_pkg::increment_skip_zero: begin
			r = (o == alu_pkg::decrement_skip_zero) ? m - 8'h01 : m + 8'h01;
			wr = 1'b1;
			sk = r == 8'h00;
		end
		alu_pkg::decrement_to_accum_skip_zero, alu_pkg::increment_to_accum_skip_zero: begin
			ea = (o == alu_pkg::decrement_to_accum_skip_zero) ? m - 8'h01 : m + 8'h01;
			sk = ea == 8'h00;
		end
		alu_pkg::fill_ones_mem, alu_pkg::set_bit_mem, alu_pkg::swap_nibbles_mem: begin
			wr = 1'b1;
			r = (o == alu_pkg::fill_ones_mem) ? 8'hFF : (o == alu_pkg::set_bit_mem) ? m | (8'h01 << bs) : {m[3:0], m[7:4]};
		end
		alu_pkg::bit_test_skip_nonzero: sk = m[bs];
		default: ;
		endcase
		@(posedge mclk);
		issue_valid <= 1'b1;
		issue <= '{op: o, operand: m, bit_sel: bs};
		@(posedge mclk);
		issue_valid <= junk;
		#1;
		chk("acc", {1'b0, ea}, {1'b0, acc});
		chk("flags", {5'h00, ef}, {1'b0, flags});
		chk("mem_wr", {wr, r}, {mem_wr.wr, mem_wr.wr ? mem_wr.data : 8'h00});
		chk("skip", {6'h00, sk, sk, sk}, {6'h00, skip_req, dummy_cycle, busy});
		if (junk) begin
			@(posedge mclk);
			issue_valid <= 1'b0;
			#1;
			chk("refused", 9'h000, {mem_wr.wr, 7'h00, skip_req});
		end
	endtask
	task automatic t_rotate();
		run(alu_pkg::minus_imm_to_accum, 8'h00, 3'h0);
		run(alu_pkg::rotate_right_carry_to_accum, 8'h02, 3'h0);
		run(alu_pkg::rotate_right_carry_to_accum, 8'h01, 3'h0);
	endtask
	task automatic t_sub();
		run(alu_pkg::minus_to_accum, 8'h01, 3'h0);
		run(alu_pkg::minus_with_borrow_to_accum, 8'h00, 3'h0);
		run(alu_pkg::minus_with_borrow_to_mem, 8'h7F, 3'h0);
		run(alu_pkg::minus_to_mem, 8'h80, 3'h0);
		run(alu_pkg::minus_imm_to_accum, 8'h80, 3'h0);
		run(alu_pkg::op_none, 8'h55, 3'h0);
	endtask
	task automatic t_skip();
		run(alu_pkg::decrement_skip_zero, 8'h01, 3'h0);
		run(alu_pkg::decrement_skip_zero, 8'h00, 3'h0);
		run(alu_pkg::decrement_to_accum_skip_zero, 8'h01, 3'h0);
		run(alu_pkg::decrement_to_accum_skip_zero, 8'h80, 3'h0);
		run(alu_pkg::increment_skip_zero, 8'hFF, 3'h0);
		run(alu_pkg::increment_skip_zero, 8'h7F, 3'h0);
		run(alu_pkg::increment_to_accum_skip_zero, 8'hFF, 3'h0);
		run(alu_pkg::increment_to_accum_skip_zero, 8'h0F, 3'h0);
		for (int i = 0; i < 8; i++) run(alu_pkg::bit_test_skip_nonzero, 8'h5A, i[2:0]);
	endtask
	task automatic t_bits();
		run(alu_pkg::fill_ones_mem, 8'h3C, 3'h0);
		for (int i = 0; i < 8; i++) run(alu_pkg::set_bit_mem, 8'h24, i[2:0]);
		run(alu_pkg::swap_nibbles_mem, 8'hA5, 3'h0);
	endtask
	task automatic t_refuse();
		run(alu_pkg::decrement_skip_zero, 8'h01, 3'h0, 1'b1);
		run(alu_pkg::minus_imm_to_accum, 8'h01, 3'h0);
	endtask
	// mid-run reset with an issue held valid; reset must win and clear acc and flags
	task automatic t_reset();
		@(posedge mclk);
		rst_n <= 1'b0;
		issue_valid <= 1'b1;
		issue <= '{op: alu_pkg::fill_ones_mem, operand: 8'h00, bit_sel: 3'h0};
		@(posedge mclk);
		#1;
		chk("acc_rst", 9'h000, {1'b0, acc});
		chk("flags_rst", 9'h000, {1'b0, flags});
		chk("mem_rst", 9'h000, {mem_wr.wr, mem_wr.data});
		@(posedge mclk);
		rst_n <= 1'b1;
		issue_valid <= 1'b0;
		ea = 8'h00;
		ef = 4'h0;
		run(alu_pkg::minus_imm_to_accum, 8'h00, 3'h0);
	endtask
	initial begin
		rst_n = 1'b0;
		issue_valid = 1'b0;
		issue = '0;
		ea = 8'h00;
		ef = 4'h0;
		n_mismatch = 0;
		comparisons = 0;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		#1;
		chk("acc_reset", 9'h000, {1'b0, acc});
		chk("flags_reset", 9'h000, {1'b0, flags});
		t_rotate();
		t_sub();
		t_skip();
		t_bits();
		t_refuse();
		t_reset();
		conclude();
	end
	// hang guard
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
endmodule
